// File: hw/smrc_top.sv
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "smrc_defines.svh"
module smrc_top
  import smrc_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          sys_rst_in,
  input  wire smrc_avm_req_t avm_req_in,
  output smrc_avm_rsp_t      avm_rsp_out,
  input  wire logic          drop_below_in,
  input  wire logic          lowvolt_below_in,
  input  wire logic          stop_mode_in,
  output logic               drop_reset_out,
  output logic               lowvolt_interrupt_out,
  output logic               lowvolt_power_out,
  output logic [2:0]         lowvolt_level_out,
  output logic               drop_monitor_on_out
);
  localparam logic [16:0] SETTLE_LAST = 17'(`SMRC_LV_SETTLE_CYC - 1);

  smrc_state_t st;
  smrc_state_t next_st;

  function automatic logic lane0_write(input smrc_avm_req_t r, input logic [1:0] a);
    lane0_write = r.write && r.byteenable[0] && (r.address == a);
  endfunction

  logic lv_out;
  logic drop_active;
  assign drop_active = !st.drop_monitor_halt && !st.drop_reset_disable;
  // Detector output counts only once settled and enabled
  assign lv_out = (st.lv_state == SMRC_LV_READY) && st.lowvolt_detect_enable && st.lv_low;

  always_comb
  begin
    next_st = st;
    next_st.drop_sync = {st.drop_sync[1:0], drop_below_in};
    if (st.drop_sync[2] == st.drop_sync[1])
    begin
      next_st.drop_low = st.drop_sync[2];
    end
    next_st.lv_sync = {st.lv_sync[1:0], lowvolt_below_in};
    if (st.lv_sync[2] == st.lv_sync[1])
    begin
      next_st.lv_low = st.lv_sync[2];
    end

    // Drop monitor runs in STOP too, so stop_mode_in is not used here
    next_st.drop_reset = drop_active && st.drop_low;

    case (st.lv_state)
      SMRC_LV_OFF:
      begin
        next_st.lv_power = 1'b0;
        if (st.lowvolt_detect_enable && !stop_mode_in)
        begin
          next_st.lv_state   = SMRC_LV_SETTLE;
          next_st.settle_cnt = 17'h00000;
          next_st.lv_power   = 1'b1;
        end
      end
      SMRC_LV_SETTLE:
      begin
        next_st.settle_cnt = st.settle_cnt + 17'h00001;
        if (st.settle_cnt == SETTLE_LAST)
        begin
          next_st.lv_state = SMRC_LV_READY;
        end
      end
      SMRC_LV_READY:
      begin
        // Enable clear keeps power; re-enable resumes at once
        next_st.lv_state = SMRC_LV_READY;
      end
      default:
      begin
        next_st.lv_state = SMRC_LV_OFF;
      end
    endcase
    if (stop_mode_in)
    begin
      next_st.lv_state = SMRC_LV_OFF;
      next_st.lv_power = 1'b0;
    end

    next_st.lv_out_prev = lv_out;

    // Single-cycle answer: waitrequest drops one cycle after request
    next_st.waitrequest = 1'b1;
    next_st.rsp_pending = 1'b0;
    if ((avm_req_in.read || avm_req_in.write) && !st.rsp_pending)
    begin
      next_st.waitrequest = 1'b0;
      next_st.rsp_pending = 1'b1;
      next_st.readdata    = 32'h00000000;
      case (avm_req_in.address)
        `SMRC_ADDR_DROP_CTRL:
        begin
          next_st.readdata[`SMRC_BIT_DROP_HALT]  = st.drop_monitor_halt;
          next_st.readdata[`SMRC_BIT_DROP_DIS]   = st.drop_reset_disable;
          next_st.readdata[`SMRC_BIT_DROP_CAUSE] = st.drop_reset_cause_flag;
        end
        `SMRC_ADDR_LV_CTRL:
        begin
          next_st.readdata[`SMRC_BIT_LV_EN]   = st.lowvolt_detect_enable;
          next_st.readdata[`SMRC_BIT_LV_FLAG] = lv_out;
        end
        `SMRC_ADDR_LV_LEVEL:
        begin
          next_st.readdata[2:0] = st.lowvolt_level;
        end
        `SMRC_ADDR_LV_INT:
        begin
          next_st.readdata[`SMRC_BIT_INT_REQ]  = st.lowvolt_int_request_flag;
          next_st.readdata[`SMRC_BIT_INT_MASK] = st.lowvolt_int_mask;
        end
        default:
        begin
          next_st.readdata = 32'h00000000;
        end
      endcase
    end

    // Writes land on the edge where waitrequest is seen low
    if (st.rsp_pending && !st.waitrequest)
    begin
      if (lane0_write(avm_req_in, `SMRC_ADDR_DROP_CTRL))
      begin
        next_st.drop_monitor_halt     = avm_req_in.writedata[`SMRC_BIT_DROP_HALT];
        next_st.drop_reset_disable    = avm_req_in.writedata[`SMRC_BIT_DROP_DIS];
        next_st.drop_reset_cause_flag = 1'b0;
      end
      if (lane0_write(avm_req_in, `SMRC_ADDR_LV_CTRL))
      begin
        next_st.lowvolt_detect_enable = avm_req_in.writedata[`SMRC_BIT_LV_EN];
      end
      if (lane0_write(avm_req_in, `SMRC_ADDR_LV_LEVEL))
      begin
        next_st.lowvolt_level = avm_req_in.writedata[2:0];
      end
      if (lane0_write(avm_req_in, `SMRC_ADDR_LV_INT))
      begin
        next_st.lowvolt_int_mask = avm_req_in.writedata[`SMRC_BIT_INT_MASK];
        if (!avm_req_in.writedata[`SMRC_BIT_INT_REQ])
        begin
          next_st.lowvolt_int_request_flag = 1'b0;
        end
      end
    end

    // Set after clear so a same-cycle edge is never lost
    if (lv_out && !st.lv_out_prev)
    begin
      next_st.lowvolt_int_request_flag = 1'b1;
    end
    next_st.lowvolt_interrupt = next_st.lowvolt_int_request_flag && !next_st.lowvolt_int_mask;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      st                       <= '0;
      st.lv_state              <= SMRC_LV_OFF;
      st.lowvolt_int_mask      <= `SMRC_INT_MASK_RESET;
      st.waitrequest           <= 1'b1;
      {st.drop_reset_cause_flag, st.drop_reset_disable, st.drop_monitor_halt} <= `SMRC_DROP_CTRL_RESET;
      // Cause flag survives the reset the monitor itself raised
      if (st.drop_reset)
      begin
        st.drop_reset_cause_flag <= 1'b1;
      end
      else
      begin
        st.drop_reset_cause_flag <= st.drop_reset_cause_flag;
      end
    end
    else
    begin
      st <= next_st;
      if (st.drop_reset)
      begin
        st.drop_reset_cause_flag <= 1'b1;
      end
    end
  end

  assign avm_rsp_out.readdata    = st.readdata;
  assign avm_rsp_out.waitrequest = st.waitrequest;
  assign drop_reset_out          = st.drop_reset;
  assign lowvolt_interrupt_out   = st.lowvolt_interrupt;
  assign lowvolt_power_out       = st.lv_power;
  assign lowvolt_level_out       = st.lowvolt_level;
  assign drop_monitor_on_out     = !st.drop_monitor_halt;
endmodule

// File: pkg/smrc_defines.svh
// Functional notes
// - Running, unmasked drop monitor resets chip while supply is below threshold.
// - A drop reset sets the sticky reset-cause flag, readable afterwards.
// - Any write touching control bits 0 to 2 clears the cause flag.
// - Enabled detector raises interrupt request when supply below selected level.
// - Detector divider and comparator power off during reset and STOP.
// - Detection starts when enable bit 7 is set; about 2 ms to settle.
// - Clearing enable does not power down comparator; only STOP or reset.
// - Re-enabling while powered resumes detection at once, no new settle delay.
// - Read-only level flag bit 0 is 1 while below level and enabled.
// - Request flag sets only on rising edge of the below-threshold output.
// - Drop control: cause bit 2, disable bit 1, halt bit 0; reset clears bits 0 and 1, cause bit keeps its value.
// - Three-bit level select picks one of eight thresholds, resets to zero.
// - Drop monitor keeps running in STOP; low-voltage detector stops.
`ifndef SMRC_DEFINES_SVH
`define SMRC_DEFINES_SVH
`define SMRC_ADDR_DROP_CTRL   2'h0
`define SMRC_ADDR_LV_CTRL     2'h1
`define SMRC_ADDR_LV_LEVEL    2'h2
`define SMRC_ADDR_LV_INT      2'h3
`define SMRC_BIT_DROP_HALT    0
`define SMRC_BIT_DROP_DIS     1
`define SMRC_BIT_DROP_CAUSE   2
`define SMRC_BIT_LV_FLAG      0
`define SMRC_BIT_LV_EN        7
`define SMRC_BIT_INT_REQ      0
`define SMRC_BIT_INT_MASK     1
`define SMRC_DROP_CTRL_RESET  3'h0
`define SMRC_INT_MASK_RESET   1'h1
`define SMRC_CLK_HZ           40000000
`define SMRC_LV_SETTLE_US     2000
`define SMRC_LV_SETTLE_CYC    ((`SMRC_CLK_HZ / 1000000) * `SMRC_LV_SETTLE_US)
`endif

// File: pkg/smrc_pkg.sv
package smrc_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [1:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } smrc_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } smrc_avm_rsp_t;

  typedef enum logic [2:0] {
    SMRC_LV_OFF    = 3'h1,
    SMRC_LV_SETTLE = 3'h2,
    SMRC_LV_READY  = 3'h4
  } smrc_lv_state_t;

  typedef struct packed {
    logic           drop_monitor_halt;
    logic           drop_reset_disable;
    logic           drop_reset_cause_flag;
    logic           lowvolt_detect_enable;
    logic [2:0]     lowvolt_level;
    logic           lowvolt_int_mask;
    logic           lowvolt_int_request_flag;
    smrc_lv_state_t lv_state;
    logic [16:0]    settle_cnt;
    logic [2:0]     drop_sync;
    logic           drop_low;
    logic [2:0]     lv_sync;
    logic           lv_low;
    logic           lv_out_prev;
    logic           drop_reset;
    logic           lowvolt_interrupt;
    logic           lv_power;
    logic           rsp_pending;
    logic [31:0]    readdata;
    logic           waitrequest;
  } smrc_state_t;
endpackage

// File: testbench/smrc_chk.sv
`timescale 1ns/1ps
module smrc_chk
  import smrc_pkg::*;
(
  input wire logic          sys_clk_in,
  input wire logic          sys_rst_in,
  input wire smrc_avm_req_t avm_req_in,
  input wire smrc_avm_rsp_t avm_rsp_out,
  input wire logic          drop_below_in,
  input wire logic          lowvolt_below_in,
  input wire logic          stop_mode_in,
  input wire logic          drop_reset_out,
  input wire logic          lowvolt_interrupt_out,
  input wire logic          lowvolt_power_out,
  input wire logic [2:0]    lowvolt_level_out,
  input wire logic          drop_monitor_on_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic rq = avm_req_in.read || avm_req_in.write;
  wire logic acc = avm_req_in.write && !avm_rsp_out.waitrequest && avm_req_in.byteenable[0];
  a_ack_next: assert property ($rose(rq) |=> !avm_rsp_out.waitrequest) else $error("late ack");
  a_ack_once: assert property (!avm_rsp_out.waitrequest |=> avm_rsp_out.waitrequest) else $error("long ack");
  a_idle_busy: assert property (!rq |-> avm_rsp_out.waitrequest) else $error("stray ack");
  a_halt_wr:
    assert property (acc && avm_req_in.address == 2'h0 |=> drop_monitor_on_out == !$past(avm_req_in.writedata[0]))
      else $error("halt bit lost");
  a_level_wr:
    assert property (acc && avm_req_in.address == 2'h2 |=> lowvolt_level_out == $past(avm_req_in.writedata[2:0]))
      else $error("level lost");
  a_halt_quiet: assert property (!drop_monitor_on_out |=> !drop_reset_out) else $error("reset while halted");
  a_drop_cause: assert property ($rose(drop_reset_out) |-> $past(drop_monitor_on_out)) else $error("bad reset");
  a_stop_off: assert property (stop_mode_in |=> !lowvolt_power_out) else $error("power in stop");
  a_power_hold:
    assert property (lowvolt_power_out && !stop_mode_in |=> lowvolt_power_out) else $error("power dropped");
  c_drop: cover property ($rose(drop_reset_out));
  c_irq: cover property ($rose(lowvolt_interrupt_out));
  c_stop: cover property (stop_mode_in && !lowvolt_power_out);
endmodule

// File: testbench/smrc_supply_model.sv
`timescale 1ns/1ps
module smrc_supply_model
(
  input  wire logic       power_in,
  input  wire logic [2:0] level_in,
  input  wire logic [7:0] supply_in,
  output logic            drop_below_out,
  output logic            lowvolt_below_out
);
  // Drop comparator ignores STOP; an unpowered detector reads low
  assign drop_below_out = supply_in < 8'h20;
  assign lowvolt_below_out = power_in && (supply_in < 8'h40 + {1'b0, level_in, 4'h0});
endmodule

// File: testbench/smrc_tb_top.sv
`timescale 1ns/1ps
`include "smrc_defines.svh"
module smrc_tb_top
  import smrc_pkg::*;
();
  logic          sys_clk_in;
  logic          sys_rst_in;
  smrc_avm_req_t avm_req_in;
  smrc_avm_rsp_t avm_rsp_out;
  logic          drop_below_in, lowvolt_below_in, stop_mode_in;
  logic          drop_reset_out, lowvolt_interrupt_out, lowvolt_power_out, drop_monitor_on_out;
  logic [2:0]    lowvolt_level_out;
  logic [7:0]    supply, rdata;
  int            errors, checks_done, cyc;
  smrc_top DUT (.*);
  smrc_supply_model u_ana (.power_in(lowvolt_power_out), .level_in(lowvolt_level_out), .supply_in(supply),
    .drop_below_out(drop_below_in), .lowvolt_below_out(lowvolt_below_in));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic final_report;
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    avm_req_in <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: {24'h0, d}};
    do
      @(posedge sys_clk_in);
    while (avm_rsp_out.waitrequest !== 1'b0);
    rdata = avm_rsp_out.readdata[7:0];
    avm_req_in.read <= 1'b0;
    avm_req_in.write <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask
  task automatic t_drop;
    bus(1'b1, 2'h0, 8'h02);
    bus(1'b1, 2'h0, 8'h03);
    supply <= 8'h10;
    repeat (10) @(posedge sys_clk_in);
    chk({7'h0, drop_reset_out}, 8'h00);
    bus(1'b1, 2'h0, 8'h02);
    repeat (10) @(posedge sys_clk_in);
    chk({7'h0, drop_reset_out}, 8'h00);
    bus(1'b1, 2'h0, 8'h00);
    repeat (6) @(posedge sys_clk_in);
    chk({7'h0, drop_reset_out}, 8'h01);
    // Bench stands in for the chip reset logic
    sys_rst_in <= 1'b1;
    supply <= 8'hF0;
    repeat (8) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(2'h0, 8'h04);
    bus(1'b1, 2'h0, 8'h00);
    rd(2'h0, 8'h00);
  endtask
  task automatic t_lv;
    bus(1'b1, 2'h2, 8'h03);
    chk({5'h0, lowvolt_level_out}, 8'h03);
    rd(2'h3, 8'h02);
    bus(1'b1, 2'h1, 8'h80);
    repeat (`SMRC_LV_SETTLE_CYC) @(posedge sys_clk_in);
    supply <= 8'h48;
    repeat (8) @(posedge sys_clk_in);
    rd(2'h1, 8'h81);
    rd(2'h3, 8'h03);
    chk({7'h0, lowvolt_interrupt_out}, 8'h00);
    bus(1'b1, 2'h3, 8'h02);
    repeat (8) @(posedge sys_clk_in);
    rd(2'h3, 8'h02);
    bus(1'b1, 2'h1, 8'h00);
    chk({7'h0, lowvolt_power_out}, 8'h01);
    rd(2'h1, 8'h00);
    bus(1'b1, 2'h1, 8'h80);
    rd(2'h1, 8'h81);
    bus(1'b1, 2'h3, 8'h00);
    supply <= 8'hF0;
    repeat (8) @(posedge sys_clk_in);
    supply <= 8'h48;
    repeat (8) @(posedge sys_clk_in);
    chk({7'h0, lowvolt_interrupt_out}, 8'h01);
    bus(1'b1, 2'h3, 8'h02);
    chk({7'h0, lowvolt_interrupt_out}, 8'h00);
    stop_mode_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk({7'h0, lowvolt_power_out}, 8'h00);
    chk({7'h0, drop_monitor_on_out}, 8'h01);
  endtask
  // Settle wait dominates the run
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      errors++;
      final_report;
    end
  end
  initial
  begin
    sys_rst_in = 1'b1;
    avm_req_in = '0;
    supply = 8'hF0;
    stop_mode_in = 1'b0;
    cyc = 0;
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_drop;
    t_lv;
    final_report;
  end
endmodule
bind smrc_top smrc_chk u_chk (.*);
